/* shared/adcwc_pkg.sv */
// package: register map, reset values and formats for the window compare
package adcwc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // special function register addresses
  localparam logic [7:0] ADDR_RESULT_LOW = 8'h_bd;
  localparam logic [7:0] ADDR_UPPER_LOW = 8'h_c3;
  localparam logic [7:0] ADDR_UPPER_HIGH = 8'h_c4;
  localparam logic [7:0] ADDR_LOWER_LOW = 8'h_c5;
  localparam logic [7:0] ADDR_LOWER_HIGH = 8'h_c6;
  localparam logic [7:0] ADDR_INPUT_SELECT = 8'h_bb;
  localparam logic [7:0] ADDR_CONTROL = 8'h_b8;

  ////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [7:0] RESET_RESULT_LOW = 8'h_00;
  localparam logic [7:0] RESET_RESULT_HIGH = 8'h_00;
  localparam logic [7:0] RESET_UPPER_LOW = 8'h_ff;
  localparam logic [7:0] RESET_UPPER_HIGH = 8'h_ff;
  localparam logic [7:0] RESET_LOWER_LOW = 8'h_00;
  localparam logic [7:0] RESET_LOWER_HIGH = 8'h_00;
  localparam logic [4:0] RESET_INPUT_SELECT = 5'h_1f;
  localparam logic [7:0] RESET_READ_DATA = 8'h_00;
  localparam logic [7:0] UNMAPPED_READ = 8'h_00;

  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CONTROL_FLAG_BIT = 3;
  localparam int INPUT_SELECT_WIDTH = 5;

  ////////////////////////////////////////////////////////////////////////
  // justify and shift setting codes
  localparam logic [2:0] JUSTIFY_RIGHT = 3'h_0;
  localparam logic [2:0] JUSTIFY_SHIFT1 = 3'h_1;
  localparam logic [2:0] JUSTIFY_SHIFT2 = 3'h_2;
  localparam logic [2:0] JUSTIFY_SHIFT3 = 3'h_3;
  localparam logic [2:0] JUSTIFY_LEFT = 3'h_4;
  // left justification moves a 10-bit result to the top of the word
  localparam int LEFT_JUSTIFY_SHIFT = 6;

endpackage

/* hw/adcwc_window_cmp.sv */
// module: combinational window decision on one formatted result word
`timescale 1ns/100ps
module adcwc_window_cmp (
  // formatted result and the two limits
  input wire logic [15:0] result_word,
  input wire logic [15:0] upper_limit,
  input wire logic [15:0] lower_limit,
  // decision
  output logic hit
);

  ////////////////////////////////////////////////////////////////////////
  logic above_upper;
  logic below_lower;
  logic inside_mode;

  // all compares unsigned, results are plain binary
  assign above_upper = result_word > upper_limit; // [R13]
  assign below_lower = result_word < lower_limit; // [R13]
  // the limit order alone picks inside or outside
  assign inside_mode = lower_limit > upper_limit; // [R7]

  // inside: strictly between; outside: strictly beyond either bound
  always_comb begin
    if (inside_mode) begin
      hit = above_upper && below_lower; // [R8]
    end else begin
      hit = above_upper || below_lower; // [R9] [R16]
    end
  end

endmodule // adcwc_window_cmp

/* hw/adcwc_top.sv */
// module: result low byte, window limits and window detector on the sfr bus
`timescale 1ns/100ps

// Functional notes
// [R1] low byte read gives formatted accumulator low
// [R2] low byte write loads accumulator low byte
// [R3] shifted read pulls in high byte low bits
// [R4] software avoids low byte writes during sync
// [R5] every result compared to limits automatically
// [R6] window flag readable in control register
// [R7] limit order alone selects inside or outside
// [R8] inside: strictly above upper, below lower
// [R9] outside: strictly below or strictly above
// [R10] upper limit: two separate byte registers
// [R11] lower limit: two separate byte registers
// [R12] software zeroes limit low bytes in 8-bit
// [R13] results compared as unsigned numbers
// [R14] one positive source chosen by select register
// [R15] software configures analog pins correctly
// [R16] upper not below lower means outside window
// [R17] compare once per result, flag sticky
// [R18] compare the formatted word, not raw bits
module adcwc_top (
  // clock and synchronous reset
  input wire logic clk,
  input wire logic rstn,
  // special function register bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // converter result stream
  input wire logic conv_done,
  input wire logic [15:0] conv_word,
  // formatting control from the converter configuration
  input wire logic [2:0] justify_shift_setting,
  // window flag and input multiplexer selection
  output logic window_flag,
  output logic [4:0] input_multiplexer_select
);

  ////////////////////////////////////////////////////////////////////////
  // compare sequencing states
  typedef enum logic [0:0] {
    CMP_IDLE,
    CMP_EVAL
  } adcwc_cmp_state_type;

  ////////////////////////////////////////////////////////////////////////
  // register declarations
  logic [7:0] acc_low_reg;
  logic [7:0] acc_low_next;
  logic [7:0] acc_high_reg;
  logic [7:0] acc_high_next;
  logic [7:0] upper_low_reg;
  logic [7:0] upper_low_next;
  logic [7:0] upper_high_reg;
  logic [7:0] upper_high_next;
  logic [7:0] lower_low_reg;
  logic [7:0] lower_low_next;
  logic [7:0] lower_high_reg;
  logic [7:0] lower_high_next;
  logic [4:0] select_reg;
  logic [4:0] select_next;
  logic flag_reg;
  logic flag_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  adcwc_cmp_state_type cmp_state_reg;
  adcwc_cmp_state_type cmp_state_next;

  ////////////////////////////////////////////////////////////////////////
  // decoded strobes and derived words
  logic wr_result_low;
  logic wr_upper_low;
  logic wr_upper_high;
  logic wr_lower_low;
  logic wr_lower_high;
  logic wr_select;
  logic wr_control;
  logic [15:0] acc_word;
  logic [15:0] formatted_word;
  logic [15:0] upper_limit;
  logic [15:0] lower_limit;
  logic window_hit;
  logic flag_set;
  logic flag_clear;
  logic [7:0] control_image;

  ////////////////////////////////////////////////////////////////////////
  // write decode; each writable byte register has its own address
  assign wr_result_low = sfr_wr && (sfr_addr == adcwc_pkg::ADDR_RESULT_LOW);
  assign wr_upper_low = sfr_wr && (sfr_addr == adcwc_pkg::ADDR_UPPER_LOW);
  assign wr_upper_high = sfr_wr && (sfr_addr == adcwc_pkg::ADDR_UPPER_HIGH);
  assign wr_lower_low = sfr_wr && (sfr_addr == adcwc_pkg::ADDR_LOWER_LOW);
  assign wr_lower_high = sfr_wr && (sfr_addr == adcwc_pkg::ADDR_LOWER_HIGH);
  assign wr_select = sfr_wr && (sfr_addr == adcwc_pkg::ADDR_INPUT_SELECT);
  assign wr_control = sfr_wr && (sfr_addr == adcwc_pkg::ADDR_CONTROL);

  ////////////////////////////////////////////////////////////////////////
  // accumulator and limit words assembled from their bytes
  assign acc_word = {acc_high_reg, acc_low_reg};
  assign upper_limit = {upper_high_reg, upper_low_reg}; // [R10]
  assign lower_limit = {lower_high_reg, lower_low_reg}; // [R11]

  // formatting: right shifts keep high byte bits flowing into the low byte
  always_comb begin
    case (justify_shift_setting)
      adcwc_pkg::JUSTIFY_RIGHT: begin
        formatted_word = acc_word;
      end
      adcwc_pkg::JUSTIFY_SHIFT1: begin
        formatted_word = acc_word >> 1; // [R3]
      end
      adcwc_pkg::JUSTIFY_SHIFT2: begin
        formatted_word = acc_word >> 2; // [R3]
      end
      adcwc_pkg::JUSTIFY_SHIFT3: begin
        formatted_word = acc_word >> 3; // [R3]
      end
      adcwc_pkg::JUSTIFY_LEFT: begin
        formatted_word = acc_word << adcwc_pkg::LEFT_JUSTIFY_SHIFT;
      end
      default: begin
        // unused codes fall back to plain right justification
        formatted_word = acc_word;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // window decision on the formatted word, never on raw converter bits
  adcwc_window_cmp u_window_cmp (
    .result_word(formatted_word), // [R18]
    .upper_limit(upper_limit),
    .lower_limit(lower_limit),
    .hit(window_hit)
  );

  ////////////////////////////////////////////////////////////////////////
  // accumulator next values: converter result wins over a software write
  // to the low byte, since a finished result must never be half overwritten
  always_comb begin
    acc_low_next = acc_low_reg;
    acc_high_next = acc_high_reg;
    if (conv_done) begin
      acc_low_next = conv_word[7:0];
      acc_high_next = conv_word[15:8];
    end else if (wr_result_low) begin
      acc_low_next = sfr_wdata; // [R2]
    end
  end

  // accumulator registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      acc_low_reg <= adcwc_pkg::RESET_RESULT_LOW;
      acc_high_reg <= adcwc_pkg::RESET_RESULT_HIGH;
    end else begin
      acc_low_reg <= acc_low_next;
      acc_high_reg <= acc_high_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // limit byte next values, each written on its own
  always_comb begin
    upper_low_next = upper_low_reg;
    upper_high_next = upper_high_reg;
    lower_low_next = lower_low_reg;
    lower_high_next = lower_high_reg;
    if (wr_upper_low) begin
      upper_low_next = sfr_wdata; // [R10]
    end
    if (wr_upper_high) begin
      upper_high_next = sfr_wdata; // [R10]
    end
    if (wr_lower_low) begin
      lower_low_next = sfr_wdata; // [R11]
    end
    if (wr_lower_high) begin
      lower_high_next = sfr_wdata; // [R11]
    end
  end

  // limit registers; reset gives an outside window that never fires
  always_ff @(posedge clk) begin
    if (!rstn) begin
      upper_low_reg <= adcwc_pkg::RESET_UPPER_LOW;
      upper_high_reg <= adcwc_pkg::RESET_UPPER_HIGH;
      lower_low_reg <= adcwc_pkg::RESET_LOWER_LOW;
      lower_high_reg <= adcwc_pkg::RESET_LOWER_HIGH;
    end else begin
      upper_low_reg <= upper_low_next;
      upper_high_reg <= upper_high_next;
      lower_low_reg <= lower_low_next;
      lower_high_reg <= lower_high_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input select next value; only the low five bits are stored
  always_comb begin
    select_next = select_reg;
    if (wr_select) begin
      select_next = sfr_wdata[adcwc_pkg::INPUT_SELECT_WIDTH-1:0]; // [R14]
    end
  end

  // input select register; one code drives exactly one source
  always_ff @(posedge clk) begin
    if (!rstn) begin
      select_reg <= adcwc_pkg::RESET_INPUT_SELECT;
    end else begin
      select_reg <= select_next;
    end
  end

  assign input_multiplexer_select = select_reg; // [R14]

  ////////////////////////////////////////////////////////////////////////
  // compare sequencing: a result lands in the accumulator, then one
  // evaluation cycle sees the freshly formatted word
  always_comb begin
    case (cmp_state_reg)
      CMP_IDLE: begin
        cmp_state_next = conv_done ? CMP_EVAL : CMP_IDLE; // [R17]
      end
      CMP_EVAL: begin
        // back to back results keep evaluating each one
        cmp_state_next = conv_done ? CMP_EVAL : CMP_IDLE; // [R5]
      end
      default: begin
        cmp_state_next = CMP_IDLE;
      end
    endcase
  end

  // compare state register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmp_state_reg <= CMP_IDLE;
    end else begin
      cmp_state_reg <= cmp_state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // window flag: sticky, hardware only sets it, software writes 0 to clear
  assign flag_set = (cmp_state_reg == CMP_EVAL) && window_hit; // [R5]
  assign flag_clear =
    wr_control && !sfr_wdata[adcwc_pkg::CONTROL_FLAG_BIT];

  // a hit in the clearing cycle must not be lost, so set wins
  always_comb begin
    flag_next = flag_reg;
    if (flag_clear) begin
      flag_next = 1'b0;
    end
    if (flag_set) begin
      flag_next = 1'b1; // [R17]
    end
  end

  // flag register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign window_flag = flag_reg; // [R6]

  ////////////////////////////////////////////////////////////////////////
  // read path; other control bits live elsewhere and read as zero here
  always_comb begin
    control_image = 8'h_00;
    control_image[adcwc_pkg::CONTROL_FLAG_BIT] = flag_reg; // [R6]
  end

  // read data mux, captured on the read strobe and held until the next
  always_comb begin
    rdata_next = rdata_reg;
    if (sfr_rd) begin
      case (sfr_addr)
        adcwc_pkg::ADDR_RESULT_LOW: begin
          rdata_next = formatted_word[7:0]; // [R1]
        end
        adcwc_pkg::ADDR_UPPER_LOW: begin
          rdata_next = upper_low_reg;
        end
        adcwc_pkg::ADDR_UPPER_HIGH: begin
          rdata_next = upper_high_reg;
        end
        adcwc_pkg::ADDR_LOWER_LOW: begin
          rdata_next = lower_low_reg;
        end
        adcwc_pkg::ADDR_LOWER_HIGH: begin
          rdata_next = lower_high_reg;
        end
        adcwc_pkg::ADDR_INPUT_SELECT: begin
          rdata_next = {3'h_0, select_reg};
        end
        adcwc_pkg::ADDR_CONTROL: begin
          rdata_next = control_image;
        end
        default: begin
          rdata_next = adcwc_pkg::UNMAPPED_READ;
        end
      endcase
    end
  end

  // read data register; data outputs come straight from flip-flops
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_reg <= adcwc_pkg::RESET_READ_DATA;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign sfr_rdata = rdata_reg;

endmodule // adcwc_top

/* verification/adcwc_cpu_model.sv */
// partner: processor core issuing sfr reads and writes
`timescale 1ns/100ps
module adcwc_cpu_model (
  // clock
  input wire logic clk,
  // sfr bus toward the block
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata
);
  // bus idle from time zero
  initial begin
    sfr_addr = 8'h_00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h_00;
  end
  // pins picked as converter inputs are made analog by other code
  // one write, entered at a falling edge; this core has no sync start
  // so a result low write can never collide with one; an idle edge
  // follows so two calls never drop and raise the strobe in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    @(negedge clk);
  endtask
  // one read; data stands from the taking edge until the next read
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    v = sfr_rdata;
    @(negedge clk);
  endtask
endmodule // adcwc_cpu_model

/* verification/adcwc_monitor.sv */
// checker: bus and window flag relations at the top ports
`timescale 1ns/100ps
module adcwc_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // converter side and outputs
  input wire logic conv_done,
  input wire logic [15:0] conv_word,
  input wire logic [2:0] justify_shift_setting,
  input wire logic window_flag,
  input wire logic [4:0] input_multiplexer_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic clr;
  logic rd_low;
  // flag clear write and a plain result low read
  assign clr = sfr_wr && sfr_addr == adcwc_pkg::ADDR_CONTROL
    && !sfr_wdata[adcwc_pkg::CONTROL_FLAG_BIT];
  assign rd_low = sfr_rd && !sfr_wr
    && sfr_addr == adcwc_pkg::ADDR_RESULT_LOW;
  flag_sticky_a: assert property (
    window_flag && !clr |=> window_flag)
    else $error("window flag dropped without a clear");
  flag_cause_a: assert property (
    $rose(window_flag) |-> $past(conv_done, 2))
    else $error("window flag rose without a result");
  // a set in the same cycle wins, hence the previous result excluded
  flag_clear_a: assert property (
    clr && !$past(conv_done) |=> !window_flag)
    else $error("window flag not cleared");
  read_hold_a: assert property (
    !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  // the bus master leaves one idle edge after every access
  limit_byte_a: assert property (
    sfr_wr && sfr_addr inside {[8'h_c3:8'h_c6]} ##1 !sfr_wr
    ##1 sfr_rd && !sfr_wr && sfr_addr == $past(sfr_addr, 2)
    |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("limit byte readback wrong");
  low_write_a: assert property (
    sfr_wr && !conv_done && sfr_addr == adcwc_pkg::ADDR_RESULT_LOW
    ##1 !conv_done && !sfr_wr ##1 rd_low
    && justify_shift_setting == adcwc_pkg::JUSTIFY_RIGHT
    |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("result low write not read back");
  low_read_a: assert property (
    conv_done ##1 rd_low
    && justify_shift_setting == adcwc_pkg::JUSTIFY_RIGHT
    |=> sfr_rdata == $past(conv_word[7:0], 2))
    else $error("result low read wrong");
  shift_read_a: assert property (
    conv_done ##1 rd_low
    && justify_shift_setting == adcwc_pkg::JUSTIFY_SHIFT2
    |=> sfr_rdata == $past(conv_word[9:2], 2))
    else $error("shifted result low read wrong");
  mux_hold_a: assert property (
    !(sfr_wr && sfr_addr == adcwc_pkg::ADDR_INPUT_SELECT)
    |=> $stable(input_multiplexer_select))
    else $error("input select moved without a write");
endmodule // adcwc_monitor

/* verification/adcwc_tb.sv */
// testbench: register access, formatting and window decisions
`timescale 1ns/100ps
module adcwc_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic sfr_wr, sfr_rd, conv_done, window_flag;
  logic [15:0] conv_word;
  logic [2:0] justify_shift_setting;
  logic [4:0] input_multiplexer_select;
  int n_mismatch = 0;
  int checked = 0;
  // 125 MHz clock
  always #4 clk = ~clk;
  adcwc_top DUT (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .conv_done(conv_done), .conv_word(conv_word),
    .justify_shift_setting(justify_shift_setting),
    .window_flag(window_flag),
    .input_multiplexer_select(input_multiplexer_select));
  adcwc_cpu_model cpu (.clk(clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
  //////////////////////////////////////////////////////////////////////////
  // comparisons and verdict
  task automatic chk(input string what, input logic [7:0] e,
    input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    cpu.rd(a, v);
    chk("register", e, v);
  endtask
  // flag seen both at the pin and in the control register
  task automatic flchk(input logic e);
    chk("window_flag", {7'h_00, e}, {7'h_00, window_flag});
    rdchk(adcwc_pkg::ADDR_CONTROL, {4'h_0, e, 3'h_0});
  endtask
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // stimulus helpers, all entered at a falling edge
  task automatic cv(input logic [15:0] w);
    conv_done = 1'b1;
    conv_word = w;
    @(negedge clk);
    conv_done = 1'b0;
  endtask
  task automatic lim(input logic [15:0] up, input logic [15:0] lo);
    cpu.wr(adcwc_pkg::ADDR_UPPER_LOW, up[7:0]);
    cpu.wr(adcwc_pkg::ADDR_UPPER_HIGH, up[15:8]);
    cpu.wr(adcwc_pkg::ADDR_LOWER_LOW, lo[7:0]);
    cpu.wr(adcwc_pkg::ADDR_LOWER_HIGH, lo[15:8]);
  endtask
  // clear, one result, then look two edges later
  task automatic win(input logic [15:0] w, input logic e);
    cpu.wr(adcwc_pkg::ADDR_CONTROL, 8'h_00);
    cv(w);
    @(negedge clk);
    flchk(e);
  endtask
  // hang guard
  initial begin
    #100000;
    n_mismatch++;
    end_of_test;
  end
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [15:0] e;
    logic [15:0] ws [10] = '{16'h_0040, 16'h_0041, 16'h_007f, 16'h_0080,
      16'h_0000, 16'h_003f, 16'h_0040, 16'h_0080, 16'h_0081, 16'h_ffff};
    logic [9:0] hit = 10'b11_0010_0110;
    conv_done = 1'b0;
    conv_word = 16'h_0000;
    justify_shift_setting = 3'h_0;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    rdchk(adcwc_pkg::ADDR_RESULT_LOW, adcwc_pkg::RESET_RESULT_LOW);
    rdchk(adcwc_pkg::ADDR_UPPER_LOW, adcwc_pkg::RESET_UPPER_LOW);
    rdchk(adcwc_pkg::ADDR_UPPER_HIGH, adcwc_pkg::RESET_UPPER_HIGH);
    rdchk(adcwc_pkg::ADDR_LOWER_LOW, adcwc_pkg::RESET_LOWER_LOW);
    rdchk(adcwc_pkg::ADDR_LOWER_HIGH, adcwc_pkg::RESET_LOWER_HIGH);
    rdchk(adcwc_pkg::ADDR_INPUT_SELECT,
      {3'h_0, adcwc_pkg::RESET_INPUT_SELECT});
    rdchk(8'h_00, adcwc_pkg::UNMAPPED_READ);
    flchk(1'b0);
    // each limit byte on its own, read back at once
    lim(16'h_a55a, 16'h_3cc3);
    rdchk(adcwc_pkg::ADDR_LOWER_HIGH, 8'h_3c);
    rdchk(adcwc_pkg::ADDR_LOWER_LOW, 8'h_c3);
    rdchk(adcwc_pkg::ADDR_UPPER_HIGH, 8'h_a5);
    rdchk(adcwc_pkg::ADDR_UPPER_LOW, 8'h_5a);
    cpu.wr(adcwc_pkg::ADDR_INPUT_SELECT, 8'h_ea);
    rdchk(adcwc_pkg::ADDR_INPUT_SELECT, 8'h_0a);
    chk("mux", 8'h_0a, {3'h_0, input_multiplexer_select});
    cpu.wr(adcwc_pkg::ADDR_RESULT_LOW, 8'h_c7);
    rdchk(adcwc_pkg::ADDR_RESULT_LOW, 8'h_c7);
    // every format code, read straight after the result lands
    for (int f = 0; f < 5; f++) begin
      justify_shift_setting = 3'(f);
      e = (f == 4) ? 16'h_b6d9 << 6 : 16'h_b6d9 >> f;
      cv(16'h_b6d9);
      rdchk(adcwc_pkg::ADDR_RESULT_LOW, e[7:0]);
    end
    // inside window first, then outside, boundaries included
    justify_shift_setting = adcwc_pkg::JUSTIFY_RIGHT;
    lim(16'h_0040, 16'h_0080);
    for (int i = 0; i < 10; i++) begin
      if (i == 5) begin
        lim(16'h_0080, 16'h_0040);
      end
      win(ws[i], hit[i]);
    end
    // a later miss leaves the flag up
    cv(16'h_0060);
    @(negedge clk);
    flchk(1'b1);
    cpu.wr(adcwc_pkg::ADDR_CONTROL, 8'h_00);
    flchk(1'b0);
    // left justified 0x0080 sits on the limit; raw 2 would be a hit
    justify_shift_setting = adcwc_pkg::JUSTIFY_LEFT;
    win(16'h_0002, 1'b0);
    // limits decided by high bytes alone, low bytes kept at zero
    lim(16'h_4000, 16'h_8000);
    win(16'h_0180, 1'b1);
    win(16'h_0200, 1'b0);
    // top bit set: a signed compare would see an outside window and hit below the lower limit
    justify_shift_setting = adcwc_pkg::JUSTIFY_RIGHT;
    lim(16'h_0040, 16'h_9000);
    win(16'h_8100, 1'b1);
    // equal limits behave as an outside window
    lim(16'h_0050, 16'h_0050);
    win(16'h_0050, 1'b0);
    win(16'h_0051, 1'b1);
    win(16'h_004f, 1'b1);
    end_of_test;
  end
endmodule // adcwc_tb

bind adcwc_top adcwc_monitor u_mon (.clk(clk), .rstn(rstn),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .conv_done(conv_done),
  .conv_word(conv_word), .justify_shift_setting(justify_shift_setting),
  .window_flag(window_flag),
  .input_multiplexer_select(input_multiplexer_select));
